// File: pbc_pkg.sv
// Package for the PWM blanking, chopping and capture block.
package pbc_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PERIOD_PS = 1_000_000_000 / CLK_HZ * 1000;
    localparam int LEB_STEP_PS = 8320;
    localparam int LEB_PS_W = 23;
    localparam logic [LEB_PS_W-1:0] CLK_STEP_PS = LEB_PS_W'(CLK_PERIOD_PS);
    localparam logic [13:0] LEB_STEP = 14'(LEB_STEP_PS);

    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_PRIMARY_TRIGGER = 4'h0;
    localparam logic [3:0] OFF_SECONDARY_TRIGGER = 4'h1;
    localparam logic [3:0] OFF_BLANKING_CONTROL = 4'h2;
    localparam logic [3:0] OFF_BLANKING_DELAY = 4'h3;
    localparam logic [3:0] OFF_AUXILIARY_CONTROL = 4'h4;
    localparam logic [3:0] OFF_TIMEBASE_CAPTURE = 4'h5;
    localparam logic [3:0] OFF_TRIGGER_MODE = 4'h6;
    localparam logic [3:0] OFF_BLANK_STATUS = 4'h7;

    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] MASK_TRIGGER = 16'hFFF8;
    localparam logic [15:0] MASK_BLANK_CTRL = 16'hFC3F;
    localparam logic [15:0] MASK_BLANK_DELAY = 16'h0FF8;
    localparam logic [15:0] MASK_AUX = 16'hCF3F;
    localparam logic [15:0] MASK_MODE = 16'h0003;

    localparam int CMP_LSB = 3;
    localparam int LEB_LSB = 3;
    localparam int LEB_W = 9;
    localparam int BC_HIGH_RISE = 15;
    localparam int BC_HIGH_FALL = 14;
    localparam int BC_LOW_RISE = 13;
    localparam int BC_LOW_FALL = 12;
    localparam int BC_FAULT_EN = 11;
    localparam int BC_CL_EN = 10;
    localparam int BC_SEL_HIGH = 5;
    localparam int BC_SEL_LOW = 4;
    localparam int BC_HH = 3;
    localparam int BC_HL = 2;
    localparam int BC_LH = 1;
    localparam int BC_LL = 0;
    localparam int AUX_FINE_PERIOD = 15;
    localparam int AUX_FINE_DUTY = 14;
    localparam int AUX_BLANK_SEL_LSB = 8;
    localparam int AUX_CHOP_SEL_LSB = 2;
    localparam int AUX_CHOP_HIGH = 1;
    localparam int AUX_CHOP_LOW = 0;
    localparam int SEL_W = 4;
    localparam int MODE_PRI_LOCAL = 0;
    localparam int MODE_SEC_LOCAL = 1;
    localparam int ST_LEB_ACTIVE = 0;
    localparam int ST_STATE_BLANK = 1;
    localparam int ST_FAULT = 2;
    localparam int ST_CURRENT_LIMIT = 3;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } pbc_reg_req_s;
endpackage : pbc_pkg

// File: pbc_input_sync.sv
// Three-stage pin synchroniser that accepts a change once stages agree.
`timescale 1ns/1ps
module pbc_input_sync #(
    parameter int W = 2
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] clean
);
    import pbc_pkg::*;

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] clean;
    } pbc_sync_s;

    pbc_sync_s q;
    pbc_sync_s next_q;

    generate
        if (W < 1) begin : g_bad_width
            $error("pbc_input_sync needs at least one bit");
        end
    endgenerate

    // Stage one feeds stage two only; the vote looks at stages two and three.
    always_comb begin
        next_q = q;
        next_q.s1 = async_in;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        next_q.clean = (q.s2 & q.s3) | (q.clean & (q.s2 | q.s3));
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else if (clk_en) begin
            q <= next_q;
        end
    end

    assign clean = q.clean;
endmodule : pbc_input_sync

// File: pbc_top.sv
// PWM channel auxiliary logic: triggers, blanking, chopping and capture.
//
// Contract
// - Hold a 13-bit secondary compare; local time base match triggers ADC.
// - Secondary compare match never raises the PWM trigger event.
// - Nine-bit blanking delay in bits 11:3, steps of 8.32 ns.
// - State blanking masks inputs while the named output sits at its level.
// - Four-bit source select; zero none, 1..9 pick a generator high output.
// - Four-bit chop select; zero internal generator, 1..9 a high output.
// - Separate chop enables for high and low outputs.
// - Current-limit leading edge copies time base into 13-bit capture field.
// - Capture belongs to the primary high-side output only.
// - Capture is taken only once leading-edge blanking has finished.
// - Capture resolution is no finer than 8.32 ns per step.
// - Bits 2:0 of trigger, delay and capture registers read zero.
// - Primary 13-bit compare triggers ADC when on the local time base.
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ps
module pbc_top #(
    parameter int TB_W = 13,
    parameter int NUM_GEN = 9
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire pbc_pkg::pbc_reg_req_s reg_req,
    output logic [15:0] rd_data,
    input wire logic [TB_W-1:0] timebase,
    input wire logic high_active,
    input wire logic low_active,
    input wire logic [NUM_GEN-1:0] gen_high,
    input wire logic chop_clock_internal,
    input wire logic fault_pin,
    input wire logic current_limit_pin,
    output logic high_side_output,
    output logic low_side_output,
    output logic adc_trigger_primary,
    output logic adc_trigger_secondary,
    output logic pwm_trigger_event,
    output logic fault_qualified,
    output logic current_limit_qualified,
    output logic fine_period_disable,
    output logic fine_duty_disable
);
    import pbc_pkg::*;

    typedef struct packed {
        logic [15:0] pri_trig;
        logic [15:0] sec_trig;
        logic [15:0] blank_ctrl;
        logic [15:0] blank_dly;
        logic [15:0] aux;
        logic [15:0] mode;
        logic [15:0] capture;
        logic [LEB_PS_W-1:0] leb_rem;
        logic high_prev;
        logic low_prev;
        logic cl_prev;
        logic [TB_W-1:0] tb_prev;
        logic high_out;
        logic low_out;
        logic adc_pri;
        logic adc_sec;
        logic pwm_trig;
        logic fault_q;
        logic cl_q;
        logic [15:0] rd_data;
    } pbc_state_s;

    pbc_state_s q;
    pbc_state_s next_q;
    logic [1:0] pins_clean;
    logic fault_c;
    logic cl_c;
    logic leb_trig;
    logic leb_active;
    logic state_blank;
    logic blank;
    logic sel_sig;
    logic chop;
    logic cl_edge;
    logic tb_new;
    logic [SEL_W-1:0] blank_sel;
    logic [SEL_W-1:0] chop_sel;
    logic [LEB_PS_W-1:0] leb_load;

    generate
        if (TB_W != 13) begin : g_bad_tb
            $error("pbc_top time base must be 13 bits wide");
        end
        if (NUM_GEN < 1 || NUM_GEN > 15) begin : g_bad_gen
            $error("pbc_top serves 1 to 15 generators");
        end
    endgenerate

    // Pins come from outside the clock domain, so they are synchronised.
    pbc_input_sync #(
        .W(2)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .async_in({fault_pin, current_limit_pin}),
        .clean(pins_clean)
    );

    assign fault_c = pins_clean[1];
    assign cl_c = pins_clean[0];

    function automatic logic pick(input logic [SEL_W-1:0] sel,
                                  input logic [NUM_GEN-1:0] v,
                                  input logic dflt);
        logic r;
        r = dflt;
        for (int i = 0; i < NUM_GEN; i++) begin
            if (sel == SEL_W'(i + 1)) begin
                r = v[i];
            end
        end
        return r;
    endfunction : pick

    always_comb begin
        next_q = q;
        blank_sel = q.aux[AUX_BLANK_SEL_LSB +: SEL_W];
        chop_sel = q.aux[AUX_CHOP_SEL_LSB +: SEL_W];
        sel_sig = pick(blank_sel, gen_high, 1'b0);
        chop = pick(chop_sel, gen_high, chop_clock_internal);
        // A code outside 1..NUM_GEN selects no blanking source at all.
        state_blank = (q.blank_ctrl[BC_HH] & high_active)
            | (q.blank_ctrl[BC_HL] & ~high_active)
            | (q.blank_ctrl[BC_LH] & low_active)
            | (q.blank_ctrl[BC_LL] & ~low_active);
        if (blank_sel != '0 && blank_sel <= SEL_W'(NUM_GEN)) begin
            state_blank = state_blank
                | (q.blank_ctrl[BC_SEL_HIGH] & sel_sig)
                | (q.blank_ctrl[BC_SEL_LOW] & ~sel_sig);
        end
        leb_trig = (q.blank_ctrl[BC_HIGH_RISE] & high_active & ~q.high_prev)
            | (q.blank_ctrl[BC_HIGH_FALL] & ~high_active & q.high_prev)
            | (q.blank_ctrl[BC_LOW_RISE] & low_active & ~q.low_prev)
            | (q.blank_ctrl[BC_LOW_FALL] & ~low_active & q.low_prev);
        // The counter holds picoseconds left, so partial steps round up.
        leb_load = {14'h0000, q.blank_dly[LEB_LSB +: LEB_W]}
            * {9'h000, LEB_STEP};
        leb_active = q.leb_rem != '0;
        blank = leb_active | state_blank;
        if (leb_trig) begin
            next_q.leb_rem = leb_load;
        end else if (q.leb_rem > CLK_STEP_PS) begin
            next_q.leb_rem = q.leb_rem - CLK_STEP_PS;
        end else begin
            next_q.leb_rem = '0;
        end
        next_q.high_prev = high_active;
        next_q.low_prev = low_active;
        next_q.fault_q = fault_c & ~(q.blank_ctrl[BC_FAULT_EN] & blank);
        next_q.cl_q = cl_c & ~(q.blank_ctrl[BC_CL_EN] & blank);
        // Capture ties to the high-side output's current-limit path.
        cl_edge = cl_c & ~q.cl_prev;
        next_q.cl_prev = cl_c;
        if (cl_edge && !(q.blank_ctrl[BC_CL_EN] && blank)) begin
            // One time base tick is a 50 ns clock, coarser than 8.32 ns.
            next_q.capture = {timebase, 3'h0};
        end
        next_q.high_out = high_active
            & (~q.aux[AUX_CHOP_HIGH] | chop);
        next_q.low_out = low_active & (~q.aux[AUX_CHOP_LOW] | chop);
        // A match fires once per time base value, not per held cycle.
        tb_new = timebase != q.tb_prev;
        next_q.tb_prev = timebase;
        next_q.adc_pri = q.mode[MODE_PRI_LOCAL] & tb_new
            & (timebase == q.pri_trig[15:CMP_LSB]);
        next_q.adc_sec = q.mode[MODE_SEC_LOCAL] & tb_new
            & (timebase == q.sec_trig[15:CMP_LSB]);
        next_q.pwm_trig = next_q.adc_pri;
        if (reg_req.wr) begin
            case (reg_req.addr)
                OFF_PRIMARY_TRIGGER: begin
                    next_q.pri_trig = reg_req.wdata & MASK_TRIGGER;
                end
                OFF_SECONDARY_TRIGGER: begin
                    next_q.sec_trig = reg_req.wdata & MASK_TRIGGER;
                end
                OFF_BLANKING_CONTROL: begin
                    next_q.blank_ctrl = reg_req.wdata & MASK_BLANK_CTRL;
                end
                OFF_BLANKING_DELAY: begin
                    next_q.blank_dly = reg_req.wdata & MASK_BLANK_DELAY;
                end
                OFF_AUXILIARY_CONTROL: begin
                    next_q.aux = reg_req.wdata & MASK_AUX;
                end
                OFF_TRIGGER_MODE: begin
                    next_q.mode = reg_req.wdata & MASK_MODE;
                end
                default: begin
                end
            endcase
        end
        next_q.rd_data = REG_RESET;
        if (reg_req.rd) begin
            case (reg_req.addr)
                OFF_PRIMARY_TRIGGER: next_q.rd_data = q.pri_trig;
                OFF_SECONDARY_TRIGGER: next_q.rd_data = q.sec_trig;
                OFF_BLANKING_CONTROL: next_q.rd_data = q.blank_ctrl;
                OFF_BLANKING_DELAY: next_q.rd_data = q.blank_dly;
                OFF_AUXILIARY_CONTROL: next_q.rd_data = q.aux;
                OFF_TIMEBASE_CAPTURE: next_q.rd_data = q.capture;
                OFF_TRIGGER_MODE: next_q.rd_data = q.mode;
                OFF_BLANK_STATUS: begin
                    next_q.rd_data[ST_LEB_ACTIVE] = leb_active;
                    next_q.rd_data[ST_STATE_BLANK] = state_blank;
                    next_q.rd_data[ST_FAULT] = fault_c;
                    next_q.rd_data[ST_CURRENT_LIMIT] = cl_c;
                end
                default: next_q.rd_data = REG_RESET;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else if (clk_en) begin
            q <= next_q;
        end
    end

    assign rd_data = q.rd_data;
    assign high_side_output = q.high_out;
    assign low_side_output = q.low_out;
    assign adc_trigger_primary = q.adc_pri;
    assign adc_trigger_secondary = q.adc_sec;
    assign pwm_trigger_event = q.pwm_trig;
    assign fault_qualified = q.fault_q;
    assign current_limit_qualified = q.cl_q;
    assign fine_period_disable = q.aux[AUX_FINE_PERIOD];
    assign fine_duty_disable = q.aux[AUX_FINE_DUTY];

    property p_sec_trigger;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && q.mode[MODE_SEC_LOCAL] && tb_new
            && timebase == q.sec_trig[15:CMP_LSB])
            |=> adc_trigger_secondary;
    endproperty
    a_sec_trigger: assert property (p_sec_trigger)
        else $error("secondary match did not trigger the converter");

    property p_no_sec_irq;
        @(posedge sys_clk) disable iff (rst)
        pwm_trigger_event |-> adc_trigger_primary;
    endproperty
    a_no_sec_irq: assert property (p_no_sec_irq)
        else $error("trigger event raised without a primary match");

    property p_pri_trigger;
        @(posedge sys_clk) disable iff (rst)
        (adc_trigger_primary && $past(clk_en))
            |-> $past(timebase) == $past(q.pri_trig[15:CMP_LSB]);
    endproperty
    a_pri_trigger: assert property (p_pri_trigger)
        else $error("primary trigger without a compare match");

    property p_delay_load;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && leb_trig && q.blank_dly == 16'h0060)
            |=> q.leb_rem == 23'd99840;
    endproperty
    a_delay_load: assert property (p_delay_load)
        else $error("blanking delay loaded a wrong time");

    property p_leb_expire;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && leb_trig && q.blank_dly == 16'h0008)
            ##1 (clk_en && !leb_trig) |=> q.leb_rem == '0;
    endproperty
    a_leb_expire: assert property (p_leb_expire)
        else $error("one-step blanking lasted longer than one cycle");

    property p_state_mask;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && q.blank_ctrl[BC_FAULT_EN] && state_blank)
            |=> !fault_qualified;
    endproperty
    a_state_mask: assert property (p_state_mask)
        else $error("fault passed during state blanking");

    property p_capture_gate;
        @(posedge sys_clk) disable iff (rst)
        (q.capture != $past(q.capture))
            |-> $past(cl_edge && !(q.blank_ctrl[BC_CL_EN] && blank));
    endproperty
    a_capture_gate: assert property (p_capture_gate)
        else $error("capture taken inside the blanking window");

    property p_capture_value;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && cl_edge && !blank)
            |=> q.capture == {$past(timebase), 3'h0};
    endproperty
    a_capture_value: assert property (p_capture_value)
        else $error("capture does not hold the time base");

    property p_chop_high;
        @(posedge sys_clk) disable iff (rst)
        (clk_en && q.aux[AUX_CHOP_HIGH])
            |=> high_side_output == ($past(high_active) && $past(chop));
    endproperty
    a_chop_high: assert property (p_chop_high)
        else $error("chopped high output is not active AND chop");

    property p_low_bits;
        @(posedge sys_clk) disable iff (rst)
        $past(reg_req.rd) |-> rd_data[2:0] == 3'h0
            || $past(reg_req.addr) == OFF_BLANKING_CONTROL
            || $past(reg_req.addr) == OFF_AUXILIARY_CONTROL
            || $past(reg_req.addr) == OFF_TRIGGER_MODE
            || $past(reg_req.addr) == OFF_BLANK_STATUS;
    endproperty
    a_low_bits: assert property (p_low_bits)
        else $error("unimplemented low bits read as nonzero");
endmodule : pbc_top

// File: pbc_far_side.sv
// Far-side model: fault and current-limit comparators plus ADC trigger sink.
`timescale 1ns/1ps
module pbc_far_side (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic want_fault,
    input wire logic want_limit,
    input wire logic adc_trigger_primary,
    input wire logic adc_trigger_secondary,
    output logic fault_pin,
    output logic current_limit_pin,
    output int adc_pri_count,
    output int adc_sec_count
);
    initial begin
        fault_pin = 1'b0;
        current_limit_pin = 1'b0;
    end

    // Comparators switch at an arbitrary moment in the cycle, so the pins
    // reach the block unrelated to its clock and must pass the synchroniser.
    always @(want_fault) begin
        #7 fault_pin = want_fault;
    end

    // The extended limit reset sits outside this block and is taken as
    // always clear, so the captured value is meaningful.
    always @(want_limit) begin
        #13 current_limit_pin = want_limit;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            adc_pri_count <= 0;
            adc_sec_count <= 0;
        end else begin
            if (adc_trigger_primary === 1'b1) begin
                adc_pri_count <= adc_pri_count + 1;
            end
            if (adc_trigger_secondary === 1'b1) begin
                adc_sec_count <= adc_sec_count + 1;
            end
        end
    end
endmodule : pbc_far_side

// File: pwm_blanking_chop_capture_tb.sv
// Self-checking testbench for the PWM blanking, chopping and capture block.
`timescale 1ns/1ps
module pwm_blanking_chop_capture_tb;
    import pbc_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    pbc_reg_req_s req = '0;
    logic [15:0] rd_data;
    logic [12:0] timebase = '0;
    logic high_active = 1'b0;
    logic low_active = 1'b0;
    logic [8:0] gen_high = '0;
    logic chop_int = 1'b0;
    logic want_fault = 1'b0;
    logic want_limit = 1'b0;
    logic clk_en = 1'b1;
    int dly[4] = '{0, 1, 12, 30};
    logic fault_pin, cl_pin, hso, lso, adc_p, adc_s, pwm_ev, fq, clq, fpd, fdd;
    int pri_n, sec_n, err_count = 0, checks = 0, cycles = 0, n;

    always #25 sys_clk = ~sys_clk;

    pbc_top i_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
        .reg_req(req), .rd_data(rd_data), .timebase(timebase),
        .high_active(high_active), .low_active(low_active),
        .gen_high(gen_high), .chop_clock_internal(chop_int),
        .fault_pin(fault_pin), .current_limit_pin(cl_pin),
        .high_side_output(hso), .low_side_output(lso),
        .adc_trigger_primary(adc_p), .adc_trigger_secondary(adc_s),
        .pwm_trigger_event(pwm_ev), .fault_qualified(fq),
        .current_limit_qualified(clq), .fine_period_disable(fpd),
        .fine_duty_disable(fdd));

    pbc_far_side i_far (.sys_clk(sys_clk), .rst(rst),
        .want_fault(want_fault), .want_limit(want_limit),
        .adc_trigger_primary(adc_p), .adc_trigger_secondary(adc_s),
        .fault_pin(fault_pin), .current_limit_pin(cl_pin),
        .adc_pri_count(pri_n), .adc_sec_count(sec_n));

    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input string name, input logic [15:0] exp,
                       input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        #1 chk("rd_data", exp, rd_data);
    endtask : rd

    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : step

    initial begin
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        for (int a = 0; a < 9; a++) rd(4'(a), REG_RESET);
        // Reserved and unimplemented bits must come back as zero.
        wr(OFF_PRIMARY_TRIGGER, 16'hFFFF);
        rd(OFF_PRIMARY_TRIGGER, 16'hFFF8);
        wr(OFF_SECONDARY_TRIGGER, 16'hFFFF);
        rd(OFF_SECONDARY_TRIGGER, 16'hFFF8);
        wr(OFF_BLANKING_DELAY, 16'hFFFF);
        rd(OFF_BLANKING_DELAY, 16'h0FF8);
        wr(OFF_TIMEBASE_CAPTURE, 16'hFFFF);
        rd(OFF_TIMEBASE_CAPTURE, 16'h0000);
        wr(OFF_AUXILIARY_CONTROL, 16'hC000);
        step(1);
        chk("fine_disable", 16'h0003, {14'h0, fpd, fdd});
        // Trigger compares, first with the local time base modes off.
        wr(OFF_PRIMARY_TRIGGER, 16'h0A08);
        wr(OFF_SECONDARY_TRIGGER, 16'h1230);
        wr(OFF_TRIGGER_MODE, 16'h0000);
        timebase <= 13'h0141;
        step(1);
        chk("trig_off", 16'h0000, {13'h0, adc_p, adc_s, pwm_ev});
        @(posedge sys_clk) timebase <= 13'h0000;
        wr(OFF_TRIGGER_MODE, 16'h0003);
        @(posedge sys_clk) timebase <= 13'h0141;
        step(1);
        chk("pri_match", 16'h0005, {13'h0, adc_p, adc_s, pwm_ev});
        step(1);
        chk("pri_once", 16'h0000, {13'h0, adc_p, adc_s, pwm_ev});
        @(posedge sys_clk) timebase <= 13'h0246;
        step(1);
        chk("sec_match", 16'h0002, {13'h0, adc_p, adc_s, pwm_ev});
        step(2);
        chk("adc_counts", 16'h0011, {8'h0, 4'(pri_n), 4'(sec_n)});
        // Chop select codes, high output chopped and low output left alone.
        @(posedge sys_clk) high_active <= 1'b1;
        low_active <= 1'b1;
        for (int k = 0; k < 10; k++) begin
            wr(OFF_AUXILIARY_CONTROL, 16'(k << 2) | 16'h0002);
            chop_int <= (k != 0);
            gen_high <= (k == 0) ? 9'h1FF : ~(9'h001 << (k - 1));
            step(2);
            chk("chop_low_src", 16'h0001, {14'h0, hso, lso});
            @(posedge sys_clk) chop_int <= (k == 0);
            gen_high <= (k == 0) ? 9'h000 : (9'h001 << (k - 1));
            step(2);
            chk("chop_high_src", 16'h0003, {14'h0, hso, lso});
        end
        // Low output chopped by a low internal clock, high output left alone.
        wr(OFF_AUXILIARY_CONTROL, 16'h0001);
        step(2);
        chk("chop_low_only", 16'h0002, {14'h0, hso, lso});
        // State blanking from the selected generator output, then from the high output level.
        wr(OFF_AUXILIARY_CONTROL, 16'h0000);
        high_active <= 1'b0;
        low_active <= 1'b0;
        want_fault <= 1'b1;
        want_limit <= 1'b1;
        wr(OFF_BLANKING_CONTROL, 16'h0C20);
        for (int k = 0; k < 10; k++) begin
            wr(OFF_AUXILIARY_CONTROL, 16'(k << 8));
            gen_high <= (k == 0) ? 9'h1FF : (9'h001 << (k - 1));
            step(6);
            chk("sel_blank", (k == 0) ? 16'h3 : 16'h0, {14'h0, fq, clq});
            @(posedge sys_clk) gen_high <= (k == 0) ? 9'h000
                : ~(9'h001 << (k - 1));
            step(6);
            chk("sel_clear", 16'h0003, {14'h0, fq, clq});
        end
        wr(OFF_BLANKING_CONTROL, 16'h0C08);
        high_active <= 1'b1;
        step(4);
        chk("hh_blank", 16'h0000, {14'h0, fq, clq});
        @(posedge sys_clk) high_active <= 1'b0;
        step(4);
        chk("hh_clear", 16'h0003, {14'h0, fq, clq});
        // Leading-edge blanking length for several delay values.
        wr(OFF_BLANKING_CONTROL, 16'h8400);
        foreach (dly[i]) begin
            automatic int d = dly[i];
            automatic int want = (d * 8320 + 49999) / 50000;
            wr(OFF_BLANKING_DELAY, 16'(d << 3));
            step(4);
            @(posedge sys_clk) high_active <= 1'b1;
            n = 0;
            for (int c = 0; c < 12; c++) begin
                step(1);
                if (clq === 1'b0) n++;
            end
            chk("leb_cycles", 16'(want), 16'(n));
            @(posedge sys_clk) high_active <= 1'b0;
        end
        // Capture refused inside the blanking window, taken outside it.
        @(posedge sys_clk) want_limit <= 1'b0;
        timebase <= 13'h0ABC;
        step(8);
        @(posedge sys_clk) high_active <= 1'b1;
        want_limit <= 1'b1;
        step(12);
        // The refused edge keeps the earlier unblanked capture of 0x246.
        rd(OFF_TIMEBASE_CAPTURE, 16'h1230);
        want_limit <= 1'b0;
        step(8);
        want_limit <= 1'b1;
        step(8);
        rd(OFF_TIMEBASE_CAPTURE, 16'h55E0);
        // A low clock enable must freeze outputs and the synchroniser.
        @(posedge sys_clk) clk_en <= 1'b0;
        high_active <= 1'b0;
        want_fault <= 1'b0;
        step(8);
        chk("frozen", 16'h0003, {14'h0, hso, fq});
        @(posedge sys_clk) clk_en <= 1'b1;
        step(8);
        chk("thawed", 16'h0000, {14'h0, hso, fq});
        tally_and_finish();
    end
endmodule : pwm_blanking_chop_capture_tb
